// ---- scid_host_model.sv ----
// scid_host_model: serial host issuing one register per frame
// assumes clk_sys at 8 ns; sclk high for 10 and low for 20 clk_sys cycles
module scid_host_model (
    input  wire logic clk_sys,
    output logic      spi_sclk,
    output logic      spi_cs_n,
    output logic      spi_sdio_in,
    input  wire logic spi_sdio_out,
    input  wire logic spi_sdio_oe,
    input  wire logic sel0_pin_out,
    input  wire logic reset_pin_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic host_d;

    // wire level: device while it drives, otherwise the host value
    assign spi_sdio_in = spi_sdio_oe ? spi_sdio_out : host_d;

    initial
    begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        host_d   = 1'b0;
    end

    // 24 bits msb first; read data sampled on rises 17 to 24
    task automatic xfer(
        input  logic [23:0] frame,
        output logic [7:0]  d3,
        output logic [7:0]  d4a,
        output logic [7:0]  d4b,
        output logic        oe_seen
    );
        int i;
        oe_seen  = 1'b0;
        spi_cs_n = 1'b0;
        for (i = 23; i >= 0; i--)
        begin
            repeat (10) @(negedge clk_sys);
            // released line toggles so a stale bit never reads as data
            if (frame[23] && i < 8)
                host_d = ~host_d;
            else
                host_d = frame[i];
            repeat (10) @(negedge clk_sys);
            spi_sclk = 1'b1;
            d3[i & 7]  = spi_sdio_in;
            d4a[i & 7] = sel0_pin_out;
            d4b[i & 7] = reset_pin_out;
            if (i < 8)
                oe_seen = oe_seen | spi_sdio_oe;
            repeat (10) @(negedge clk_sys);
            spi_sclk = 1'b0;
        end
        repeat (10) @(negedge clk_sys);
        spi_cs_n = 1'b1;
        repeat (10) @(negedge clk_sys);
    endtask : xfer
endmodule : scid_host_model

// ---- scid_pin_sync.sv ----
// scid_pin_sync: three-stage synchroniser with agreement filter
// assumes inputs are asynchronous pins; output changes once the second
// and third stages agree
module scid_pin_sync
    import scid_pkg::*;
#(
    parameter int               WIDTH   = 3,
    parameter logic [WIDTH-1:0] RST_VAL = '0
)(
    input  wire logic             clk_sys,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage3_r;
    logic [WIDTH-1:0] level_r;
    logic [WIDTH-1:0] level_nxt;

    if (WIDTH < 1)
    begin : g_bad_width
        $error("scid_pin_sync: WIDTH must be at least 1");
    end

    // a bit moves only when stages two and three agree
    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            level_nxt[i] = (stage2_r[i] == stage3_r[i]) ? stage3_r[i]
                                                        : level_r[i];
        end
    end

    // meta_r is read by stage2_r only
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            meta_r   <= RST_VAL;
            stage2_r <= RST_VAL;
            stage3_r <= RST_VAL;
            level_r  <= RST_VAL;
        end
        else
        begin
            meta_r   <= din;
            stage2_r <= meta_r;
            stage3_r <= stage2_r;
            level_r  <= level_nxt;
        end
    end

    assign dout = level_r;

endmodule : scid_pin_sync

// ---- scid_pkg.sv ----
// scid_pkg: constants and types shared by the system control block
// assumes a byte wide register space behind a 24-bit serial frame
package scid_pkg;

    // serial frame layout: 1 direction bit, 15 address bits, 8 data bits
    localparam int         ADDR_W           = 15;
    localparam int         DATA_W           = 8;
    localparam int         FRAME_W          = 24;
    localparam logic [4:0] HDR_LAST_BIT     = 5'h0F;
    localparam logic [4:0] HDR_BITS         = 5'h10;
    localparam logic [4:0] FRAME_LAST_BIT   = 5'h17;
    localparam int         DIR_BIT_POS      = 15;
    localparam logic       DIR_READ         = 1'b1;

    // register offsets
    localparam logic [14:0] OFF_SOFT_RESET  = 15'h0000;
    localparam logic [14:0] OFF_SLEEP       = 15'h0002;
    localparam logic [14:0] OFF_PART_TYPE   = 15'h0003;
    localparam logic [14:0] OFF_PROD_HI     = 15'h0004;
    localparam logic [14:0] OFF_PROD_LO     = 15'h0005;
    localparam logic [14:0] OFF_SI_REV      = 15'h0006;
    localparam logic [14:0] OFF_MAKER_HI    = 15'h000C;
    localparam logic [14:0] OFF_MAKER_LO    = 15'h000D;

    // field positions
    localparam int SOFT_RESET_BIT           = 7;
    localparam int THREE_WIRE_OFF_BIT       = 4;
    localparam int SLEEP_BIT                = 0;

    // reset values
    localparam logic SOFT_RESET_RST         = 1'b0;
    localparam logic THREE_WIRE_OFF_RST     = 1'b0;
    localparam logic SLEEP_RST              = 1'b0;

    // one less than the clk_sys cycles the internal reset is held after the cycle of the soft reset write
    localparam int SOFT_RESET_HOLD_CYCLES   = 4;

    // pin synchroniser depth
    localparam int SYNC_STAGES              = 3;

    typedef enum logic [1:0] {
        SCID_HEADER = 2'b00,
        SCID_LOAD   = 2'b01,
        SCID_DATA   = 2'b10,
        SCID_DONE   = 2'b11
    } scid_state_t;

endpackage : scid_pkg

// ---- scid_reg_bank.sv ----
// scid_reg_bank: soft reset, wire mode, sleep and identification registers
// assumes single-cycle write strobes from the serial engine
module scid_reg_bank
    import scid_pkg::*;
#(
    parameter logic [7:0]  PART_TYPE_CODE = 8'h3C,  // arbitrary value
    parameter logic [15:0] PRODUCT_CODE   = 16'hA55A, // arbitrary value
    parameter logic [7:0]  SI_REV_CODE    = 8'h12,  // arbitrary value
    parameter logic [15:0] MAKER_CODE     = 16'h00B7, // arbitrary value
    parameter int          RESET_HOLD     = SOFT_RESET_HOLD_CYCLES
)(
    input  wire logic  clk_sys,
    input  wire logic  reset,
    scid_reg_if.bank   rif,
    output logic       device_reset,
    output logic       three_wire_readback_off,
    output logic       sleep_request
);

    localparam int CNT_W = $clog2(RESET_HOLD + 1);
    localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(RESET_HOLD);

    logic             three_wire_off_r;
    logic             three_wire_off_nxt;
    logic             sleep_r;
    logic             sleep_nxt;
    logic [CNT_W-1:0] hold_cnt_r;
    logic [CNT_W-1:0] hold_cnt_nxt;
    logic             dev_rst_r;
    logic             dev_rst_nxt;
    logic             wr_ctrl;
    logic             wr_sleep;

    if (RESET_HOLD < 1)
    begin : g_bad_hold
        $error("scid_reg_bank: RESET_HOLD must be at least 1");
    end

    // read decode; unmapped offsets and reserved bits read zero
    function automatic logic [7:0] read_mux(input logic [14:0] a,
                                            input logic        busy,
                                            input logic        tw_off,
                                            input logic        slp);
        logic [7:0] d;
        d = 8'h00;
        case (a)
            OFF_SOFT_RESET:
            begin
                d[SOFT_RESET_BIT]     = busy;
                d[THREE_WIRE_OFF_BIT] = tw_off;
            end
            OFF_SLEEP:     d[SLEEP_BIT] = slp;
            OFF_PART_TYPE: d = PART_TYPE_CODE;
            OFF_PROD_HI:   d = PRODUCT_CODE[15:8];
            OFF_PROD_LO:   d = PRODUCT_CODE[7:0];
            OFF_SI_REV:    d = SI_REV_CODE;
            OFF_MAKER_HI:  d = MAKER_CODE[15:8];
            OFF_MAKER_LO:  d = MAKER_CODE[7:0];
            default:       d = 8'h00;
        endcase
        return d;
    endfunction : read_mux

    // only offsets 0 and 2 accept writes; identification bytes ignore them
    assign wr_ctrl  = rif.wr_stb && (rif.addr == OFF_SOFT_RESET);
    assign wr_sleep = rif.wr_stb && (rif.addr == OFF_SLEEP);

    // soft reset holds the device in reset, then drops by itself
    always_comb
    begin
        three_wire_off_nxt = three_wire_off_r;
        sleep_nxt          = sleep_r;
        hold_cnt_nxt       = hold_cnt_r;
        dev_rst_nxt        = 1'b0;
        if (hold_cnt_r != '0)
        begin
            // full reset: every setting back to its power-on value
            hold_cnt_nxt       = hold_cnt_r - CNT_W'(1);
            dev_rst_nxt        = 1'b1;
            three_wire_off_nxt = THREE_WIRE_OFF_RST;
            sleep_nxt          = SLEEP_RST;
        end
        else if (wr_ctrl && rif.wdata[SOFT_RESET_BIT])
        begin
            hold_cnt_nxt       = HOLD_LOAD;
            dev_rst_nxt        = 1'b1;
            three_wire_off_nxt = THREE_WIRE_OFF_RST;
            sleep_nxt          = SLEEP_RST;
        end
        else
        begin
            if (wr_ctrl)
                three_wire_off_nxt = rif.wdata[THREE_WIRE_OFF_BIT];
            if (wr_sleep)
                sleep_nxt = rif.wdata[SLEEP_BIT];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            three_wire_off_r <= THREE_WIRE_OFF_RST;
            sleep_r          <= SLEEP_RST;
            hold_cnt_r       <= '0;
            dev_rst_r        <= SOFT_RESET_RST;
        end
        else
        begin
            three_wire_off_r <= three_wire_off_nxt;
            sleep_r          <= sleep_nxt;
            hold_cnt_r       <= hold_cnt_nxt;
            dev_rst_r        <= dev_rst_nxt;
        end
    end

    assign rif.rdata = read_mux(rif.addr, dev_rst_r, three_wire_off_r,
                                sleep_r);
    assign device_reset            = dev_rst_r;
    assign three_wire_readback_off = three_wire_off_r;
    assign sleep_request           = sleep_r;

endmodule : scid_reg_bank

// ---- scid_reg_if.sv ----
// scid_reg_if: register access path from serial engine to register bank
// assumes both ends run on clk_sys; rdata is combinational from addr
interface scid_reg_if;
    logic        wr_stb;
    logic [14:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;

    modport engine (output wr_stb, output addr, output wdata, input rdata);
    modport bank   (input wr_stb, input addr, input wdata, output rdata);
endinterface : scid_reg_if

// ---- scid_sys_ctrl.sv ----
// scid_sys_ctrl: serial slave and system control registers of the clock
// conditioner. all serial pins are sampled on clk_sys, so the serial clock
// must stay high and low for at least 8 clk_sys periods each.
// the pin-function selections come from registers on the same clock.
//
// Contract
// - writing one to bit 7 at offset 0 resets the device and the bit clears.
// - bit 4 at offset 0 turns 3-wire readback off when one, on when zero.
// - after power-on the soft reset and 3-wire-off bits read zero.
// - 4-wire readback appears only on a pin whose function selects it.
// - 3-wire and 4-wire readback may run together.
// - bit 0 at offset 2 puts the whole device to sleep while set.
// - offset 3 reads a fixed 8-bit part type code.
// - offsets 4 and 5 read the fixed 16-bit product code, high byte first.
// - offset 6 reads a fixed 8-bit silicon revision code.
// - offsets 0xC and 0xD read the fixed 16-bit maker code, high first.
module scid_sys_ctrl
    import scid_pkg::*;
#(
    parameter logic [7:0]  PART_TYPE_CODE = 8'h3C,    // arbitrary value
    parameter logic [15:0] PRODUCT_CODE   = 16'hA55A, // arbitrary value
    parameter logic [7:0]  SI_REV_CODE    = 8'h12,    // arbitrary value
    parameter logic [15:0] MAKER_CODE     = 16'h00B7, // arbitrary value
    parameter int          RESET_HOLD     = SOFT_RESET_HOLD_CYCLES
)(
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic spi_sclk,
    input  wire logic spi_cs_n,
    input  wire logic spi_sdio_in,
    output logic      spi_sdio_out,
    output logic      spi_sdio_oe,
    input  wire logic input_select0_pin_function_rb,
    input  wire logic reset_pin_function_rb,
    output logic      sel0_pin_out,
    output logic      sel0_pin_oe,
    output logic      reset_pin_out,
    output logic      reset_pin_oe,
    output logic      device_reset,
    output logic      three_wire_readback_off,
    output logic      sleep_request
);

    // filtered pin levels: {sclk, cs_n, sdio}
    logic [2:0]  pins_f;
    logic        sclk_f;
    logic        cs_n_f;
    logic        sdio_f;
    logic        sclk_rise;
    logic        sclk_fall;

    // engine state
    scid_state_t state_r;
    scid_state_t state_nxt;
    logic [4:0]  bit_cnt_r;
    logic [4:0]  bit_cnt_nxt;
    logic [23:0] shift_r;
    logic [23:0] shift_nxt;
    logic        rd_r;
    logic        rd_nxt;
    logic [14:0] addr_r;
    logic [14:0] addr_nxt;
    logic [7:0]  tx_r;
    logic [7:0]  tx_nxt;
    logic        sending_r;
    logic        sending_nxt;
    logic        wr_stb_r;
    logic        wr_stb_nxt;
    logic [7:0]  wdata_r;
    logic [7:0]  wdata_nxt;
    logic        sclk_prev_r;

    // pin drive registers
    logic        sdio_out_r;
    logic        sdio_out_nxt;
    logic        sdio_oe_r;
    logic        sdio_oe_nxt;
    logic        sel0_out_r;
    logic        sel0_out_nxt;
    logic        sel0_oe_r;
    logic        sel0_oe_nxt;
    logic        rstp_out_r;
    logic        rstp_out_nxt;
    logic        rstp_oe_r;
    logic        rstp_oe_nxt;

    logic        tw_off;

    scid_reg_if rif ();

    if (FRAME_W != int'(FRAME_LAST_BIT) + 1)
    begin : g_bad_frame
        $error("scid_sys_ctrl: frame length and bit counter disagree");
    end

    // cs_n idles high so a frame never starts out of reset
    scid_pin_sync #(
        .WIDTH   (3),
        .RST_VAL (3'h2)
    ) u_pin_sync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .din     ({spi_sclk, spi_cs_n, spi_sdio_in}),
        .dout    (pins_f)
    );

    assign sclk_f = pins_f[2];
    assign cs_n_f = pins_f[1];
    assign sdio_f = pins_f[0];

    scid_reg_bank #(
        .PART_TYPE_CODE (PART_TYPE_CODE),
        .PRODUCT_CODE   (PRODUCT_CODE),
        .SI_REV_CODE    (SI_REV_CODE),
        .MAKER_CODE     (MAKER_CODE),
        .RESET_HOLD     (RESET_HOLD)
    ) u_reg_bank (
        .clk_sys                 (clk_sys),
        .reset                   (reset),
        .rif                     (rif),
        .device_reset            (device_reset),
        .three_wire_readback_off (tw_off),
        .sleep_request           (sleep_request)
    );

    assign three_wire_readback_off = tw_off;

    // register access travels on the interface
    assign rif.wr_stb = wr_stb_r;
    assign rif.addr   = addr_r;
    assign rif.wdata  = wdata_r;

    // edges of the filtered serial clock
    assign sclk_rise = sclk_f && !sclk_prev_r;
    assign sclk_fall = !sclk_f && sclk_prev_r;

    // frame engine: data in on rising edges, readback moves on falling
    always_comb
    begin
        state_nxt   = state_r;
        bit_cnt_nxt = bit_cnt_r;
        shift_nxt   = shift_r;
        rd_nxt      = rd_r;
        addr_nxt    = addr_r;
        tx_nxt      = tx_r;
        sending_nxt = sending_r;
        wr_stb_nxt  = 1'b0;
        wdata_nxt   = wdata_r;
        if (cs_n_f)
        begin
            // deselect aborts any frame; a partial write is dropped
            state_nxt   = SCID_HEADER;
            bit_cnt_nxt = '0;
            sending_nxt = 1'b0;
            tx_nxt      = 8'h00;
        end
        else
        begin
            case (state_r)
                SCID_HEADER:
                begin
                    if (sclk_rise)
                    begin
                        shift_nxt   = {shift_r[22:0], sdio_f};
                        bit_cnt_nxt = bit_cnt_r + 5'h01;
                        if (bit_cnt_r == HDR_LAST_BIT)
                        begin
                            rd_nxt    = shift_nxt[DIR_BIT_POS] == DIR_READ;
                            addr_nxt  = shift_nxt[14:0];
                            state_nxt = SCID_LOAD;
                        end
                    end
                end
                SCID_LOAD:
                begin
                    // address settled last cycle, read data is now valid
                    if (rd_r)
                    begin
                        tx_nxt      = rif.rdata;
                        sending_nxt = 1'b1;
                    end
                    state_nxt = SCID_DATA;
                end
                SCID_DATA:
                begin
                    if (sclk_rise)
                    begin
                        shift_nxt   = {shift_r[22:0], sdio_f};
                        bit_cnt_nxt = bit_cnt_r + 5'h01;
                        if (bit_cnt_r == FRAME_LAST_BIT)
                        begin
                            state_nxt = SCID_DONE;
                            if (!rd_r)
                            begin
                                wr_stb_nxt = 1'b1;
                                wdata_nxt  = shift_nxt[7:0];
                            end
                        end
                    end
                    else if (sclk_fall && bit_cnt_r > HDR_BITS)
                    begin
                        // the fall after the 16th rise keeps bit 7 up
                        tx_nxt = {tx_r[6:0], 1'b0};
                    end
                end
                SCID_DONE:
                begin
                    // extra clocks are ignored until deselect
                    if (sclk_fall)
                    begin
                        sending_nxt = 1'b0;
                        tx_nxt      = 8'h00;
                    end
                end
                default:
                begin
                    state_nxt = SCID_HEADER;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            state_r     <= SCID_HEADER;
            bit_cnt_r   <= '0;
            shift_r     <= '0;
            rd_r        <= 1'b0;
            addr_r      <= '0;
            tx_r        <= 8'h00;
            sending_r   <= 1'b0;
            wr_stb_r    <= 1'b0;
            wdata_r     <= 8'h00;
            sclk_prev_r <= 1'b0;
        end
        else
        begin
            state_r     <= state_nxt;
            bit_cnt_r   <= bit_cnt_nxt;
            shift_r     <= shift_nxt;
            rd_r        <= rd_nxt;
            addr_r      <= addr_nxt;
            tx_r        <= tx_nxt;
            sending_r   <= sending_nxt;
            wr_stb_r    <= wr_stb_nxt;
            wdata_r     <= wdata_nxt;
            sclk_prev_r <= sclk_f;
        end
    end

    // readback pins: 3-wire shares sdio, 4-wire uses a selected output pin;
    // both may drive the same bit at once
    always_comb
    begin
        sdio_oe_nxt  = sending_nxt && !tw_off;
        sdio_out_nxt = sdio_oe_nxt && tx_nxt[7];
        sel0_oe_nxt  = input_select0_pin_function_rb;
        sel0_out_nxt = input_select0_pin_function_rb && sending_nxt
                       && tx_nxt[7];
        rstp_oe_nxt  = reset_pin_function_rb;
        rstp_out_nxt = reset_pin_function_rb && sending_nxt
                       && tx_nxt[7];
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            sdio_out_r <= 1'b0;
            sdio_oe_r  <= 1'b0;
            sel0_out_r <= 1'b0;
            sel0_oe_r  <= 1'b0;
            rstp_out_r <= 1'b0;
            rstp_oe_r  <= 1'b0;
        end
        else
        begin
            sdio_out_r <= sdio_out_nxt;
            sdio_oe_r  <= sdio_oe_nxt;
            sel0_out_r <= sel0_out_nxt;
            sel0_oe_r  <= sel0_oe_nxt;
            rstp_out_r <= rstp_out_nxt;
            rstp_oe_r  <= rstp_oe_nxt;
        end
    end

    assign spi_sdio_out  = sdio_out_r;
    assign spi_sdio_oe   = sdio_oe_r;
    assign sel0_pin_out  = sel0_out_r;
    assign sel0_pin_oe   = sel0_oe_r;
    assign reset_pin_out = rstp_out_r;
    assign reset_pin_oe  = rstp_oe_r;

endmodule : scid_sys_ctrl

// ---- scid_sys_ctrl_props.sv ----
// scid_sys_ctrl_props: port-level checks of the system control block
// assumes clk_sys domain only; bound onto every scid_sys_ctrl
module scid_sys_ctrl_props #(
    parameter int RESET_HOLD = 4
)(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic spi_cs_n,
    input wire logic input_select0_pin_function_rb,
    input wire logic reset_pin_function_rb,
    input wire logic spi_sdio_out,
    input wire logic spi_sdio_oe,
    input wire logic sel0_pin_out,
    input wire logic sel0_pin_oe,
    input wire logic reset_pin_oe,
    input wire logic device_reset,
    input wire logic three_wire_readback_off,
    input wire logic sleep_request
);
    logic [3:0] hold_cnt_r;
    logic [3:0] hold_cnt_nxt;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    // length of the soft reset pulse, read back when it falls
    always_comb
    begin
        hold_cnt_nxt = device_reset ? hold_cnt_r + 4'h1 : 4'h0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            hold_cnt_r <= 4'h0;
        else
            hold_cnt_r <= hold_cnt_nxt;
    end

    a_por_values: assert property ($fell(reset) |->
        !three_wire_readback_off && !sleep_request && !device_reset)
        else $error("bits not clear after reset");
    a_pulse_len: assert property ($fell(device_reset) |->
        hold_cnt_r == 4'(RESET_HOLD + 1))
        else $error("soft reset pulse length wrong");
    a_rst_by_write: assert property ($rose(device_reset) |->
        !spi_cs_n)
        else $error("soft reset outside a frame");
    a_rst_clears_mode: assert property (device_reset &&
        $past(device_reset) |-> !three_wire_readback_off && !sleep_request)
        else $error("mode bits kept during soft reset");
    a_mode_by_frame: assert property (($changed(sleep_request) ||
        $changed(three_wire_readback_off)) |-> !spi_cs_n)
        else $error("mode bit changed without a frame");
    a_three_wire_off: assert property (three_wire_readback_off |->
        !spi_sdio_oe)
        else $error("sdio driven while 3-wire off");
    a_idle_quiet: assert property (spi_cs_n[*8] |->
        !spi_sdio_oe && !sel0_pin_out)
        else $error("readback driven while deselected");
    a_sel_pin_on: assert property ((!reset &&
        input_select0_pin_function_rb)[*3] |-> sel0_pin_oe)
        else $error("selected readback pin not driven");
    a_rst_pin_off: assert property ((!reset &&
        !reset_pin_function_rb)[*3] |-> !reset_pin_oe)
        else $error("unselected pin driven");
    a_same_bits: assert property (spi_sdio_oe && sel0_pin_oe |->
        spi_sdio_out == sel0_pin_out)
        else $error("3-wire and 4-wire bits differ");
endmodule : scid_sys_ctrl_props

bind scid_sys_ctrl scid_sys_ctrl_props #(.RESET_HOLD(RESET_HOLD)) u_props (
    .clk_sys                       (clk_sys),
    .reset                         (reset),
    .spi_cs_n                      (spi_cs_n),
    .input_select0_pin_function_rb (input_select0_pin_function_rb),
    .reset_pin_function_rb         (reset_pin_function_rb),
    .spi_sdio_out                  (spi_sdio_out),
    .spi_sdio_oe                   (spi_sdio_oe),
    .sel0_pin_out                  (sel0_pin_out),
    .sel0_pin_oe                   (sel0_pin_oe),
    .reset_pin_oe                  (reset_pin_oe),
    .device_reset                  (device_reset),
    .three_wire_readback_off       (three_wire_readback_off),
    .sleep_request                 (sleep_request)
);

// ---- tb_top.sv ----
// tb_top: register accesses through the serial host model
// assumes soft reset length shortened to RH; id codes are arbitrary
module tb_top
    import scid_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int          RH = 2;
    localparam logic [7:0]  PT = 8'h5B;    // arbitrary value
    localparam logic [15:0] PC = 16'hC3E1; // arbitrary value
    localparam logic [7:0]  SR = 8'h2D;    // arbitrary value
    localparam logic [15:0] MC = 16'h9F27; // arbitrary value
    localparam logic [14:0] IDA [6] = '{OFF_PART_TYPE, OFF_PROD_HI,
        OFF_PROD_LO, OFF_SI_REV, OFF_MAKER_HI, OFF_MAKER_LO};
    localparam logic [7:0]  IDD [6] = '{PT, PC[15:8], PC[7:0], SR,
        MC[15:8], MC[7:0]};
    logic       clk_sys, reset, sel_rb, rst_rb, sclk, cs_n, sdio_in;
    logic       sdio_out, sdio_oe, sel_out, sel_oe, rst_out, rst_oe;
    logic       dev_rst, tw_off, sleep_req, oe_seen;
    logic [7:0] d3, d4a, d4b;
    int         miscompares = 0;
    int         compares = 0;
    int         rst_cycles = 0;
    int         i;

    scid_sys_ctrl #(.PART_TYPE_CODE(PT), .PRODUCT_CODE(PC),
        .SI_REV_CODE(SR), .MAKER_CODE(MC), .RESET_HOLD(RH)) dut (
        .clk_sys(clk_sys), .reset(reset), .spi_sclk(sclk),
        .spi_cs_n(cs_n), .spi_sdio_in(sdio_in), .spi_sdio_out(sdio_out),
        .spi_sdio_oe(sdio_oe), .input_select0_pin_function_rb(sel_rb),
        .reset_pin_function_rb(rst_rb), .sel0_pin_out(sel_out),
        .sel0_pin_oe(sel_oe), .reset_pin_out(rst_out),
        .reset_pin_oe(rst_oe), .device_reset(dev_rst),
        .three_wire_readback_off(tw_off), .sleep_request(sleep_req));

    scid_host_model host (.clk_sys(clk_sys), .spi_sclk(sclk),
        .spi_cs_n(cs_n), .spi_sdio_in(sdio_in), .spi_sdio_out(sdio_out),
        .spi_sdio_oe(sdio_oe), .sel0_pin_out(sel_out),
        .reset_pin_out(rst_out));

    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // soft reset pulse length, measured independently of the checker
    always @(negedge clk_sys)
        if (dev_rst === 1'b1)
            rst_cycles++;

    task automatic end_sim();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk8

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        host.xfer({~DIR_READ, a, d}, d3, d4a, d4b, oe_seen);
    endtask : wr

    // three_w: whether sdio readback is expected to be driven
    task automatic rd(input logic [14:0] a, input logic [7:0] exp,
                      input logic three_w);
        host.xfer({DIR_READ, a, 8'h00}, d3, d4a, d4b, oe_seen);
        chk8({7'h00, oe_seen}, {7'h00, three_w});
        if (three_w)
            chk8(d3, exp);
        if (sel_rb)
            chk8(d4a, exp);
        if (rst_rb)
            chk8(d4b, exp);
    endtask : rd

    initial
    begin
        #400000;
        miscompares++;
        end_sim();
    end

    initial
    begin
        reset  = 1'b1;
        sel_rb = 1'b0;
        rst_rb = 1'b0;
        repeat (4) @(negedge clk_sys);
        reset = 1'b0;
        repeat (8) @(negedge clk_sys);
        rd(OFF_SOFT_RESET, 8'h00, 1'b1);
        rd(OFF_SLEEP, 8'h00, 1'b1);
        chk8({6'h00, sel_oe, rst_oe}, 8'h00);
        sel_rb = 1'b1;
        rst_rb = 1'b1;
        repeat (4) @(negedge clk_sys);
        for (i = 0; i < 6; i++)
        begin
            rd(IDA[i], IDD[i], 1'b1);
            wr(IDA[i], ~IDD[i]);
            rd(IDA[i], IDD[i], 1'b1);
        end
        wr(15'h0001, 8'hA5);
        rd(15'h0001, 8'h00, 1'b1);
        wr(OFF_SLEEP, 8'h01);
        chk8({7'h00, sleep_req}, 8'h01);
        rd(OFF_SLEEP, 8'h01, 1'b1);
        wr(OFF_SLEEP, 8'h00);
        chk8({7'h00, sleep_req}, 8'h00);
        wr(OFF_SOFT_RESET, 8'h10);
        chk8({7'h00, tw_off}, 8'h01);
        rd(OFF_SOFT_RESET, 8'h10, 1'b0);
        wr(OFF_SOFT_RESET, 8'h00);
        rd(OFF_SOFT_RESET, 8'h00, 1'b1);
        wr(OFF_SOFT_RESET, 8'h10);
        wr(OFF_SLEEP, 8'h01);
        wr(OFF_SOFT_RESET, 8'h80);
        chk8(8'(rst_cycles), 8'(RH + 1));
        chk8({6'h00, tw_off, sleep_req}, 8'h00);
        rd(OFF_SOFT_RESET, 8'h00, 1'b1);
        end_sim();
    end
endmodule : tb_top
